/* shared/mru_regs.svh */
// Purpose: offsets, field positions, reset values of the mode update bank
// Assumes: 32-bit AHB-Lite words, byte addresses decoded on haddr[7:0]
// Notes:   definitions only
`ifndef MRU_REGS_SVH
`define MRU_REGS_SVH
// register byte offsets
`define MRU_OFF_MODE      8'h00
`define MRU_OFF_WDOG      8'h04
`define MRU_OFF_RSTSRC    8'h08
`define MRU_OFF_TRX       8'h0C
`define MRU_OFF_SUPPLY    8'h10
`define MRU_OFF_NVCFG     8'h14
`define MRU_OFF_NVSTAT    8'h18
`define MRU_OFF_PN_ID     8'h1C
`define MRU_OFF_PN_MASK   8'h20
`define MRU_OFF_PN_FRAME  8'h24
`define MRU_OFF_DMASK_LO  8'h28
`define MRU_OFF_DMASK_HI  8'h2C
`define MRU_OFF_EVT_STAT  8'h30
`define MRU_OFF_EVT_CLR   8'h34
`define MRU_OFF_EVT_EN    8'h38
// field positions
`define MRU_WDOG_WMC_LSB  4
`define MRU_SUP_SENS_LSB  4
`define MRU_FRM_PN_DATA_MASK_ENABLE_BIT  6
`define MRU_FRM_CDR_LSB   8
`define MRU_TRX_TXACT     0
`define MRU_TRX_SILENT    1
`define MRU_TRX_PNERR     2
`define MRU_TRX_OSC       3
`define MRU_TRX_DOMTO     4
`define MRU_TRX_NMS       5
`define MRU_EVT_PO        0
`define MRU_EVT_SYSTEM_EVENT_SUMMARY      1
`define MRU_EVT_SILENT    2
`define MRU_EVT_DOMTO     3
`define MRU_EVT_DROP      4
// reset and mode-entry values
`define MRU_MC_DEF        3'h4
`define MRU_MC_NORMAL     3'h7
`define MRU_MC_SLEEP      3'h1
`define MRU_NWP_DEF       4'h4
`define MRU_RSS_DEF       5'h00
`define MRU_RSS_OTEMP     5'h12
`define MRU_WMC_SWDEV     3'h1
`define MRU_WMC_STD       3'h2
`define MRU_DM_DEF        8'hFF
`define MRU_CDR_DEF       3'h5
`define MRU_TRX_DEF       6'h26
`define MRU_EVT_DEF       5'h03
`endif

/* shared/mru_pkg.sv */
// Purpose: types of the mode update bank
// Assumes: mode codes come from the mode state machine on i_mclk
// Notes:   gray codes along off, standby, normal, sleep
package mru_pkg;
   typedef enum logic [2:0] {
      MRU_OFF     = 3'h0,
      MRU_STANDBY = 3'h1,
      MRU_NORMAL  = 3'h3,
      MRU_SLEEP   = 3'h2,
      MRU_OTEMP   = 3'h6,
      MRU_RESET   = 3'h7
   } mru_mode_t;

   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } mru_ahb_req_t;

   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } mru_ahb_rsp_t;

   // live transceiver state, link side
   typedef struct packed {
      logic tx_active;
      logic bus_silent;
      logic pn_config_error;
      logic pn_oscillator_status;
      logic tx_dominant_timeout_status;
   } mru_live_t;

   // stored configuration and memory state
   typedef struct packed {
      logic       forced_normal_config;
      logic [1:0] restart_limit_config;
      logic       software_dev_config;
      logic       sleep_control_config;
      logic [1:0] supply_threshold_startup;
      logic [1:0] sensor_supply_startup;
      logic       nv_ecc_status;
      logic       nv_programmed_status;
      logic [5:0] nv_write_count_status;
   } mru_nv_t;

   typedef struct packed {
      logic        lclk_s1;
      logic        lclk_s2;
      logic        lclk_s3;
      mru_live_t   live_s1;
      mru_live_t   live_s2;
      mru_mode_t   mode_prev;
      logic        por;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      mru_mode_t   wr_mode;
      logic [31:0] rdata;
      logic [2:0]  mc;
      logic [3:0]  nominal_watchdog_period;
      logic [2:0]  watchdog_mode_field;
      logic [4:0]  reset_source_status;
      logic [5:0]  trx;
      logic [1:0]  sup_thr;
      logic [1:0]  sens_ctl;
      logic [28:0] pn_id;
      logic [28:0] pn_mask;
      logic [3:0]  frame_length_code;
      logic        pn_data_mask_enable;
      logic [2:0]  data_rate_select;
      logic [63:0] dmask;
      logic [4:0]  evt;
      logic [4:0]  evt_en;
   } mru_state_t;
endpackage

/* hw/mru_bank.sv */
// Purpose: mode driven register bank with AHB-Lite register access
// Assumes: i_mode, i_nv, i_reset_cause on i_mclk; i_link_clk, i_live async
// Notes:   zero wait state slave, always OKAY
`timescale 1ns/1ns
`include "mru_regs.svh"
module mru_bank (
   // clock and reset
   input  wire logic                  i_mclk,
   input  wire logic                  i_reset,
   // register bus
   input  wire mru_pkg::mru_ahb_req_t i_ahb,
   output      mru_pkg::mru_ahb_rsp_t o_ahb,
   // mode, memory and link
   input  wire mru_pkg::mru_mode_t    i_mode,
   input  wire mru_pkg::mru_nv_t      i_nv,
   input  wire logic [4:0]            i_reset_cause,
   input  wire logic                  i_link_clk,
   input  wire mru_pkg::mru_live_t    i_live,
   // controls to the chip
   output      logic [2:0]            o_mode_control_field,
   output      logic [3:0]            o_nominal_watchdog_period,
   output      logic [2:0]            o_watchdog_mode_field,
   output      logic [1:0]            o_supply_reset_threshold,
   output      logic [1:0]            o_sensor_supply_control,
   output      logic                  o_irq
);
   import mru_pkg::*;

   localparam mru_state_t ST_RST = '{
      lclk_s1: 1'b0, lclk_s2: 1'b0, lclk_s3: 1'b0,
      live_s1: '0, live_s2: '0, mode_prev: MRU_OFF, por: 1'b1,
      wr_pend: 1'b0, wr_addr: 8'h00, wr_mode: MRU_OFF, rdata: 32'h0,
      mc: `MRU_MC_DEF, nominal_watchdog_period: `MRU_NWP_DEF, watchdog_mode_field: `MRU_WMC_STD,
      reset_source_status: `MRU_RSS_DEF, trx: `MRU_TRX_DEF, sup_thr: 2'h0, sens_ctl: 2'h0,
      pn_id: 29'h0, pn_mask: 29'h0, frame_length_code: 4'h0, pn_data_mask_enable: 1'b1,
      data_rate_select: `MRU_CDR_DEF, dmask: {8{`MRU_DM_DEF}},
      evt: `MRU_EVT_DEF, evt_en: 5'h00};

   mru_state_t q;
   mru_state_t d;
   logic       acc;
   logic       entry;
   logic       link_edge;
   logic       do_wr;
   logic       drop;
   logic [4:0] evt_set;
   logic [4:0] evt_clr;
   logic [31:0] wd;

   function automatic logic [31:0] rd_mux(input mru_state_t s,
                                          input mru_nv_t nv,
                                          input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0;
      unique case (a)
         `MRU_OFF_MODE:     r[2:0] = s.mc;
         `MRU_OFF_WDOG: begin
            r[3:0] = s.nominal_watchdog_period;
            r[`MRU_WDOG_WMC_LSB +: 3] = s.watchdog_mode_field;
         end
         `MRU_OFF_RSTSRC:   r[4:0] = s.reset_source_status;
         `MRU_OFF_TRX:      r[5:0] = s.trx;
         `MRU_OFF_SUPPLY: begin
            r[1:0] = s.sup_thr;
            r[`MRU_SUP_SENS_LSB +: 2] = s.sens_ctl;
         end
         `MRU_OFF_NVCFG:    r[8:0] = nv[16:8];
         `MRU_OFF_NVSTAT:   r[7:0] = nv[7:0];
         `MRU_OFF_PN_ID:    r[28:0] = s.pn_id;
         `MRU_OFF_PN_MASK:  r[28:0] = s.pn_mask;
         `MRU_OFF_PN_FRAME: begin
            r[3:0] = s.frame_length_code;
            r[`MRU_FRM_PN_DATA_MASK_ENABLE_BIT] = s.pn_data_mask_enable;
            r[`MRU_FRM_CDR_LSB +: 3] = s.data_rate_select;
         end
         `MRU_OFF_DMASK_LO: r = s.dmask[31:0];
         `MRU_OFF_DMASK_HI: r = s.dmask[63:32];
         `MRU_OFF_EVT_STAT: r[4:0] = s.evt;
         `MRU_OFF_EVT_EN:   r[4:0] = s.evt_en;
         default:           r = 32'h0;
      endcase
      return r;
   endfunction

   always_comb begin
      d = q;
      // two stage synchronisers; stage one feeds stage two only
      d.lclk_s1 = i_link_clk;
      d.lclk_s2 = q.lclk_s1;
      d.lclk_s3 = q.lclk_s2;
      d.live_s1 = i_live;
      d.live_s2 = q.live_s1;
      link_edge = q.lclk_s2 & ~q.lclk_s3;
      entry = (i_mode != q.mode_prev);
      d.mode_prev = i_mode;
      d.por = 1'b0;
      evt_set = 5'h00;
      evt_clr = 5'h00;
      wd = i_ahb.hwdata;

      // address phase
      acc = i_ahb.hsel & i_ahb.htrans[1] & i_ahb.hready;
      d.wr_pend = acc & i_ahb.hwrite;
      if (acc) begin
         d.wr_addr = i_ahb.haddr[7:0];
         d.wr_mode = i_mode;
      end
      if (acc & ~i_ahb.hwrite) begin
         d.rdata = rd_mux(q, i_nv, i_ahb.haddr[7:0]);
      end

      // data phase; a mode change wins over the access
      do_wr = q.wr_pend & ~entry & (i_mode == q.wr_mode);
      drop = q.wr_pend & ~do_wr;
      if (do_wr) begin
         unique case (q.wr_addr)
            `MRU_OFF_MODE: d.mc = wd[2:0];
            `MRU_OFF_WDOG: begin
               d.nominal_watchdog_period = wd[3:0];
               d.watchdog_mode_field = wd[`MRU_WDOG_WMC_LSB +: 3];
            end
            `MRU_OFF_SUPPLY: begin
               d.sup_thr  = wd[1:0];
               d.sens_ctl = wd[`MRU_SUP_SENS_LSB +: 2];
            end
            `MRU_OFF_PN_ID:    d.pn_id = wd[28:0];
            `MRU_OFF_PN_MASK:  d.pn_mask = wd[28:0];
            `MRU_OFF_PN_FRAME: begin
               d.frame_length_code  = wd[3:0];
               d.pn_data_mask_enable = wd[`MRU_FRM_PN_DATA_MASK_ENABLE_BIT];
               d.data_rate_select  = wd[`MRU_FRM_CDR_LSB +: 3];
            end
            `MRU_OFF_DMASK_LO: d.dmask[31:0] = wd;
            `MRU_OFF_DMASK_HI: d.dmask[63:32] = wd;
            `MRU_OFF_EVT_CLR:  evt_clr = wd[4:0];
            `MRU_OFF_EVT_EN:   d.evt_en = wd[4:0];
            default: ;
         endcase
      end

      // live status captured on link clock rising edges
      if (link_edge) begin
         d.trx[`MRU_TRX_PNERR] = q.live_s2.pn_config_error;
         d.trx[`MRU_TRX_OSC]   = q.live_s2.pn_oscillator_status;
         d.trx[`MRU_TRX_DOMTO] =
            q.live_s2.tx_dominant_timeout_status;
         if (i_mode != MRU_SLEEP) begin
            d.trx[`MRU_TRX_SILENT] = q.live_s2.bus_silent;
         end
         d.trx[`MRU_TRX_TXACT] = q.live_s2.tx_active;
         evt_set[`MRU_EVT_SILENT] = q.live_s2.bus_silent &
            ~q.trx[`MRU_TRX_SILENT] & (i_mode != MRU_SLEEP);
         evt_set[`MRU_EVT_DOMTO] = q.live_s2.tx_dominant_timeout_status &
            ~q.trx[`MRU_TRX_DOMTO];
      end
      if (i_mode != MRU_NORMAL) begin
         d.trx[`MRU_TRX_TXACT] = 1'b0;
      end
      evt_set[`MRU_EVT_DROP] = drop;

      // mode entry updates; other bits hold
      if (entry) begin
         unique case (i_mode)
            MRU_STANDBY: d.mc = `MRU_MC_DEF;
            MRU_NORMAL: begin
               d.mc = `MRU_MC_NORMAL;
               d.trx[`MRU_TRX_NMS] = 1'b0;
            end
            MRU_SLEEP: d.mc = `MRU_MC_SLEEP;
            MRU_OTEMP: begin
               d.nominal_watchdog_period = `MRU_NWP_DEF;
               d.reset_source_status = `MRU_RSS_OTEMP;
            end
            MRU_RESET: begin
               d.mc  = `MRU_MC_DEF;
               d.nominal_watchdog_period = `MRU_NWP_DEF;
               d.reset_source_status = i_reset_cause;
               d.watchdog_mode_field = i_nv.software_dev_config ? `MRU_WMC_SWDEV
                                                : `MRU_WMC_STD;
            end
            default: ;
         endcase
      end

      // sticky events, set beats clear
      d.evt = (q.evt & ~evt_clr) | evt_set;
      if (|evt_set) begin
         d.evt[`MRU_EVT_SYSTEM_EVENT_SUMMARY] = 1'b1;
      end

      // off mode and power-on: every bit to its default
      if (i_mode == MRU_OFF || q.por) begin
         d.mc      = `MRU_MC_DEF;
         d.nominal_watchdog_period     = `MRU_NWP_DEF;
         d.reset_source_status     = `MRU_RSS_DEF;
         d.trx     = `MRU_TRX_DEF;
         d.watchdog_mode_field     = i_nv.software_dev_config ? `MRU_WMC_SWDEV
                                              : `MRU_WMC_STD;
         d.pn_id   = 29'h0;
         d.pn_mask = 29'h0;
         d.frame_length_code     = 4'h0;
         d.pn_data_mask_enable    = 1'b1;
         d.data_rate_select     = `MRU_CDR_DEF;
         d.dmask   = {8{`MRU_DM_DEF}};
         d.sup_thr  = i_nv.supply_threshold_startup;
         d.sens_ctl = i_nv.sensor_supply_startup;
         d.evt     = `MRU_EVT_DEF;
         d.evt_en  = 5'h00;
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   assign o_ahb.hrdata    = q.rdata;
   assign o_ahb.hreadyout = 1'b1;
   assign o_ahb.hresp     = 1'b0;
   assign o_mode_control_field      = q.mc;
   assign o_nominal_watchdog_period = q.nominal_watchdog_period;
   assign o_watchdog_mode_field     = q.watchdog_mode_field;
   assign o_supply_reset_threshold  = q.sup_thr;
   assign o_sensor_supply_control   = q.sens_ctl;
   assign o_irq = |(q.evt & q.evt_en);

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);

   sequence s_wr_addr;
      acc && i_ahb.hwrite && i_ahb.haddr[7:0] == `MRU_OFF_WDOG;
   endsequence
   sequence s_mode_moves;
      i_mode != q.mode_prev && !q.por;
   endsequence
   sequence s_enter(mru_mode_t m);
      i_mode == m && q.mode_prev != m && !q.por;
   endsequence

   write_dropped_a: assert property (
      s_wr_addr ##1 s_mode_moves |=> q.evt[`MRU_EVT_DROP] && $stable(q.nominal_watchdog_period)
         || $past(i_mode) == MRU_OTEMP || $past(i_mode) == MRU_RESET
         || $past(i_mode) == MRU_OFF)
      else $error("write kept across a mode change");
   off_defaults_a: assert property (
      i_mode == MRU_OFF |=> q.dmask == {8{`MRU_DM_DEF}}
         && q.data_rate_select == `MRU_CDR_DEF && q.evt == `MRU_EVT_DEF
         && q.evt_en == 5'h00 && q.pn_id == 29'h0)
      else $error("off mode left a bit off default");
   mc_normal_a: assert property (
      s_enter(MRU_NORMAL) |=> o_mode_control_field == `MRU_MC_NORMAL)
      else $error("mode control not 111 after normal entry");
   mc_sleep_a: assert property (
      s_enter(MRU_SLEEP) |=> o_mode_control_field == `MRU_MC_SLEEP)
      else $error("mode control not 001 after sleep entry");
   wdog_reload_a: assert property (
      s_enter(MRU_OTEMP) or s_enter(MRU_RESET)
         |=> o_nominal_watchdog_period == `MRU_NWP_DEF)
      else $error("watchdog period not reloaded");
   rss_reset_a: assert property (
      s_enter(MRU_RESET) |=> q.reset_source_status == $past(i_reset_cause))
      else $error("reset source not the cause");
   rss_otemp_a: assert property (
      s_enter(MRU_OTEMP) |=> q.reset_source_status == `MRU_RSS_OTEMP)
      else $error("reset source not 10010 on overtemp");
   tx_forced_a: assert property (
      i_mode != MRU_NORMAL |=> !q.trx[`MRU_TRX_TXACT])
      else $error("transmitter active outside normal");
   silence_hold_a: assert property (
      i_mode == MRU_SLEEP && q.mode_prev == MRU_SLEEP && !q.por
         |=> $stable(q.trx[`MRU_TRX_SILENT]))
      else $error("bus silence moved in sleep");
   nms_clear_a: assert property (
      s_enter(MRU_NORMAL) |=> !q.trx[`MRU_TRX_NMS] [*2]
         or ##1 i_mode == MRU_OFF)
      else $error("normal entry flag not cleared");
   wmc_load_a: assert property (
      s_enter(MRU_RESET) |=> o_watchdog_mode_field ==
         ($past(i_nv.software_dev_config) ? `MRU_WMC_SWDEV : `MRU_WMC_STD))
      else $error("watchdog mode wrong after reset");
   evt_sticky_a: assert property (
      q.evt[`MRU_EVT_DROP] && i_mode != MRU_OFF && !q.wr_pend
         |=> q.evt[`MRU_EVT_DROP] && q.evt[`MRU_EVT_SYSTEM_EVENT_SUMMARY])
      else $error("event flag lost");

   sequence s_off_or_por;
      i_mode == MRU_OFF || q.por;
   endsequence
   sequence s_steady;
      i_mode != MRU_OFF && !q.por && (i_mode == q.mode_prev
         || i_mode == MRU_STANDBY || i_mode == MRU_NORMAL
         || i_mode == MRU_SLEEP);
   endsequence

   off_mc_a: assert property (
      s_off_or_por |=> o_mode_control_field == `MRU_MC_DEF)
      else $error("mode control not 100 in off");
   off_nwp_a: assert property (
      s_off_or_por |=> o_nominal_watchdog_period == `MRU_NWP_DEF)
      else $error("watchdog period not 0100 in off");
   off_rss_a: assert property (
      s_off_or_por |=> q.reset_source_status == `MRU_RSS_DEF)
      else $error("reset source not cleared in off");
   off_trx_a: assert property (
      s_off_or_por |=> q.trx == `MRU_TRX_DEF)
      else $error("status bits not at defaults in off");
   off_wmc_a: assert property (
      s_off_or_por |=> o_watchdog_mode_field ==
         ($past(i_nv.software_dev_config) ? `MRU_WMC_SWDEV : `MRU_WMC_STD))
      else $error("watchdog mode wrong at power-on");
   off_pn_a: assert property (
      s_off_or_por |=> q.pn_mask == 29'h0 && q.frame_length_code == 4'h0 && q.pn_data_mask_enable
         && q.dmask == {8{`MRU_DM_DEF}})
      else $error("filter fields not at defaults");
   off_supply_a: assert property (
      s_off_or_por |=> o_supply_reset_threshold ==
         $past(i_nv.supply_threshold_startup) && o_sensor_supply_control
         == $past(i_nv.sensor_supply_startup))
      else $error("supply controls not from startup settings");
   off_events_a: assert property (
      s_off_or_por |=> q.evt == `MRU_EVT_DEF && q.evt_en == 5'h00)
      else $error("events not at defaults");
   mc_standby_a: assert property (
      s_enter(MRU_STANDBY) |=> o_mode_control_field == `MRU_MC_DEF)
      else $error("mode control not 100 after standby entry");
   mc_reset_a: assert property (
      s_enter(MRU_RESET) |=> o_mode_control_field == `MRU_MC_DEF)
      else $error("mode control not 100 after reset entry");
   nwp_hold_a: assert property (
      s_steady ##0 !q.wr_pend |=> $stable(q.nominal_watchdog_period) && $stable(q.watchdog_mode_field))
      else $error("watchdog fields moved without cause");
   rss_hold_a: assert property (
      s_steady |=> $stable(q.reset_source_status))
      else $error("reset source moved without cause");
   nms_hold_a: assert property (
      i_mode != MRU_NORMAL && i_mode != MRU_OFF && !q.por
         |=> $stable(q.trx[`MRU_TRX_NMS]))
      else $error("normal entry flag moved outside normal");
   tx_live_a: assert property (
      link_edge && i_mode == MRU_NORMAL && !q.por
         |=> q.trx[`MRU_TRX_TXACT] == $past(q.live_s2.tx_active))
      else $error("transmitter active not live in normal");
   silence_track_a: assert property (
      link_edge && i_mode != MRU_SLEEP && i_mode != MRU_OFF && !q.por
         |=> q.trx[`MRU_TRX_SILENT] == $past(q.live_s2.bus_silent))
      else $error("bus silence not tracked");
   live_track_a: assert property (
      link_edge && i_mode != MRU_OFF && !q.por |=>
         q.trx[`MRU_TRX_PNERR] == $past(q.live_s2.pn_config_error)
         && q.trx[`MRU_TRX_OSC] == $past(q.live_s2.pn_oscillator_status))
      else $error("live status not captured");
   nv_cfg_read_a: assert property (
      acc && !i_ahb.hwrite && i_ahb.haddr[7:0] == `MRU_OFF_NVCFG
         |=> o_ahb.hrdata == {23'h0, $past(i_nv[16:8])})
      else $error("stored configuration read wrong");
   nv_stat_read_a: assert property (
      acc && !i_ahb.hwrite && i_ahb.haddr[7:0] == `MRU_OFF_NVSTAT
         |=> o_ahb.hrdata == {24'h0, $past(i_nv[7:0])})
      else $error("memory status read wrong");
   drop_event_a: assert property (
      q.wr_pend && i_mode != q.mode_prev && i_mode != MRU_OFF
         |=> q.evt[`MRU_EVT_DROP])
      else $error("dropped write not flagged");
endmodule

/* dv/mru_link_model.sv */
// Purpose: transceiver side model feeding link clock and live status
// Assumes: link clock period 800 ns, idle low between frames
// Notes:   live status moves on the falling link edge only
`timescale 1ns/1ns
module mru_link_model (
   // frame control
   input  wire logic              i_run,
   input  wire mru_pkg::mru_live_t i_live_next,
   // link pins
   output      logic              o_link_clk,
   output      mru_pkg::mru_live_t o_live
);
   import mru_pkg::*;
   initial begin
      o_link_clk = 1'b0;
      o_live = '0;
      forever begin
         wait (i_run);
         // odd offset keeps link edges off the system clock edges
         #13 o_link_clk = 1'b1;
         #400 o_link_clk = 1'b0;
         o_live = i_live_next;
         #387;
      end
   end
endmodule

/* dv/tb.sv */
// Purpose: self-checking bench of the mode update bank
// Assumes: zero wait AHB-Lite slave, 100 ns system clock
// Notes:   random values from a fixed xorshift seed
`timescale 1ns/1ns
`include "mru_regs.svh"
`define CHK(nm, ex, got) begin \
   samples_checked++; \
   if ((got) !== (ex)) begin \
      mismatches++; \
      $display("wrong value %s exp %h got %h", nm, ex, got); \
   end \
end
module tb;
   import mru_pkg::*;
   logic         i_mclk, i_reset, hsel, hwrite, link_run, link_clk, irq;
   logic [31:0]  haddr, hwdata, rd, seed;
   logic [1:0]   htrans, thr_o, sens_o;
   logic [2:0]   mc_o, wmc_o;
   logic [3:0]   nwp_o;
   logic [4:0]   cause, e_rss;
   logic         e_nms, e_sil;
   mru_mode_t    mode, nxt_mode;
   mru_nv_t      nv;
   mru_live_t    live_next, live;
   mru_ahb_req_t req;
   mru_ahb_rsp_t rsp;
   int           mismatches, samples_checked;
   logic [7:0]   ha [8] = '{`MRU_OFF_MODE, `MRU_OFF_WDOG, `MRU_OFF_SUPPLY,
      `MRU_OFF_PN_ID, `MRU_OFF_PN_MASK, `MRU_OFF_PN_FRAME,
      `MRU_OFF_DMASK_LO, `MRU_OFF_DMASK_HI};
   logic [31:0]  hm [8] = '{32'h7, 32'h7F, 32'h33, 32'h1FFFFFFF,
      32'h1FFFFFFF, 32'h74F, 32'hFFFFFFFF, 32'hFFFFFFFF};
   logic [31:0]  hx [8];
   mru_mode_t    seq [10] = '{MRU_NORMAL, MRU_SLEEP, MRU_STANDBY, MRU_OTEMP,
      MRU_SLEEP, MRU_RESET, MRU_NORMAL, MRU_OTEMP, MRU_RESET, MRU_STANDBY};
   mru_mode_t    lseq [5] = '{MRU_STANDBY, MRU_NORMAL, MRU_SLEEP, MRU_OTEMP,
      MRU_RESET};

   assign req = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};

   mru_bank dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ahb(req),
      .o_ahb(rsp), .i_mode(mode), .i_nv(nv), .i_reset_cause(cause),
      .i_link_clk(link_clk), .i_live(live), .o_mode_control_field(mc_o),
      .o_nominal_watchdog_period(nwp_o), .o_watchdog_mode_field(wmc_o),
      .o_supply_reset_threshold(thr_o), .o_sensor_supply_control(sens_o),
      .o_irq(irq));

   mru_link_model link (.i_run(link_run), .i_live_next(live_next),
      .o_link_clk(link_clk), .o_live(live));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (rsp.hreadyout !== 1'b1 && n < 64);
      if (n >= 64) begin
         mismatches++;
         test_done();
      end
   endtask

   // address phase, then data phase; optional mode change in data phase
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, input logic drop);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      if (drop) mode <= nxt_mode;
      wait_rdy();
      rd = rsp.hrdata;
      `CHK("okay response", 1'b0, rsp.hresp)
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 1'b0);
   endtask

   task automatic rck(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
      bus(a, 1'b0, 32'h0, 1'b0);
      `CHK(nm, e, rd)
   endtask

   task automatic chk_held();
      for (int i = 2; i < 8; i++) rck(ha[i], hx[i], "held reg");
      `CHK("supply pins", {hx[2][5:4], hx[2][1:0]}, {sens_o, thr_o})
   endtask

   task automatic defaults();
      hx = '{32'h4, 32'h0, 32'h0, 32'h0, 32'h0, 32'h540, 32'hFFFFFFFF,
             32'hFFFFFFFF};
      hx[1] = {25'h0, (nv.software_dev_config ? 3'h1 : 3'h2), 4'h4};
      hx[2] = {26'h0, nv.sensor_supply_startup, 2'h0,
               nv.supply_threshold_startup};
      e_rss = 5'h00;
      e_nms = 1'b1;
      e_sil = 1'b1;
      for (int i = 0; i < 8; i++) rck(ha[i], hx[i], "default");
      rck(`MRU_OFF_RSTSRC, 32'h0, "reset source");
      rck(`MRU_OFF_TRX, 32'h26, "trx default");
      rck(`MRU_OFF_EVT_STAT, 32'h3, "event default");
      rck(`MRU_OFF_EVT_EN, 32'h0, "enable default");
      `CHK("watchdog pins", hx[1][6:0], {wmc_o, nwp_o})
   endtask

   task automatic enter(input mru_mode_t m);
      logic [31:0] r;
      r = rnd();
      mode <= m;
      nv <= r[16:0];
      cause <= r[28:24];
      repeat (3) @(posedge i_mclk);
      if (m == MRU_NORMAL) e_nms = 1'b0;
      if (m == MRU_NORMAL) hx[0] = 32'h7;
      if (m == MRU_SLEEP) hx[0] = 32'h1;
      if (m == MRU_STANDBY || m == MRU_RESET) hx[0] = 32'h4;
      if (m == MRU_OTEMP || m == MRU_RESET) hx[1][3:0] = 4'h4;
      if (m == MRU_OTEMP) e_rss = 5'h12;
      if (m == MRU_RESET) e_rss = cause;
      if (m == MRU_RESET) hx[1][6:4] = nv.software_dev_config ? 3'h1 : 3'h2;
      rck(`MRU_OFF_MODE, hx[0], "mode control");
      rck(`MRU_OFF_WDOG, hx[1], "watchdog");
      rck(`MRU_OFF_RSTSRC, e_rss, "reset source");
      rck(`MRU_OFF_NVCFG, nv[16:8], "nv config");
      rck(`MRU_OFF_NVSTAT, nv[7:0], "nv status");
      bus(`MRU_OFF_TRX, 1'b0, 32'h0, 1'b0);
      `CHK("normal entry", e_nms, rd[5])
      `CHK("mode pins", hx[0][2:0], mc_o)
      chk_held();
   endtask

   task automatic link_chk(input mru_mode_t m);
      logic [31:0] r;
      enter(m);
      r = rnd();
      live_next <= r[4:0];
      link_run <= 1'b1;
      repeat (26) @(posedge i_mclk);
      link_run <= 1'b0;
      repeat (10) @(posedge i_mclk);
      if (m != MRU_SLEEP) e_sil = live_next.bus_silent;
      rck(`MRU_OFF_TRX, {26'h0, e_nms, live_next.tx_dominant_timeout_status,
          live_next.pn_oscillator_status, live_next.pn_config_error, e_sil,
          live_next.tx_active & (m == MRU_NORMAL)}, "trx live");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end

   initial begin
      #2000000;
      mismatches++;
      test_done();
   end

   initial begin
      logic [31:0] r;
      seed = 32'h0000AF9B;
      {hsel, hwrite, link_run, htrans, haddr, hwdata} = '0;
      mismatches = 0;
      samples_checked = 0;
      r = rnd();
      nv = r[16:0];
      cause = 5'h00;
      live_next = '0;
      mode = MRU_STANDBY;
      nxt_mode = MRU_NORMAL;
      i_reset = 1'b1;
      repeat (8) @(posedge i_mclk);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_mclk);
      defaults();
      $display("test power-on defaults done");
      for (int i = 0; i < 2; i++) begin
         wr(`MRU_OFF_EVT_EN, 32'h1 << i);
         repeat (2) @(posedge i_mclk);
         `CHK("irq set", 1'b1, irq)
         wr(`MRU_OFF_EVT_CLR, 32'h1 << i);
         repeat (2) @(posedge i_mclk);
         `CHK("irq clear", 1'b0, irq)
      end
      rck(`MRU_OFF_EVT_STAT, 32'h0, "events cleared");
      $display("test interrupt done");
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         wr(ha[i], r);
         hx[i] = r & hm[i];
      end
      wr(8'h40, r);
      rck(8'h40, 32'h0, "unmapped");
      wr(`MRU_OFF_RSTSRC, r);
      rck(`MRU_OFF_RSTSRC, 32'h0, "read only");
      foreach (seq[i]) enter(seq[i]);
      $display("test mode walk done");
      wr(`MRU_OFF_EVT_EN, 32'h10);
      bus(`MRU_OFF_WDOG, 1'b1, ~hx[1], 1'b1);
      repeat (3) @(posedge i_mclk);
      hx[0] = 32'h7;
      e_nms = 1'b0;
      rck(`MRU_OFF_WDOG, hx[1], "dropped write");
      rck(`MRU_OFF_EVT_STAT, 32'h12, "drop event");
      `CHK("drop irq", 1'b1, irq)
      $display("test dropped write done");
      foreach (lseq[i]) link_chk(lseq[i]);
      $display("test live status done");
      mode <= MRU_OFF;
      repeat (3) @(posedge i_mclk);
      defaults();
      wr(`MRU_OFF_PN_ID, rnd());
      rck(`MRU_OFF_PN_ID, 32'h0, "write in off");
      $display("test off mode done");
      r = rnd();
      nv <= r[16:0];
      mode <= MRU_STANDBY;
      i_reset <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_mclk);
      defaults();
      $display("test second reset done");
      test_done();
   end
endmodule
